// File: inc/temp_results_pkg.sv
// package for the temperature result register bank
// assumes a 10 MHz system clock and a 16-bit register port
package temp_results_pkg;
    // register offsets
    localparam logic [7:0] OFF_PORT1_TEMP_INTEGER = 8'hE7;
    localparam logic [7:0] OFF_PORT1_TEMP_FRACTION = 8'hE8;
    localparam logic [7:0] OFF_PORT2_TEMP_INTEGER = 8'hEB;
    localparam logic [7:0] OFF_PORT2_TEMP_FRACTION = 8'hEC;
    localparam logic [7:0] OFF_TEMP_CYCLES_AVERAGED = 8'hEF;
    localparam logic [7:0] OFF_PORT1_AVG_INTEGER = 8'hF0;
    localparam logic [7:0] OFF_PORT1_AVG_FRACTION = 8'hF1;
    localparam logic [7:0] OFF_PORT2_AVG_INTEGER = 8'hF4;
    localparam logic [7:0] OFF_PORT2_AVG_FRACTION = 8'hF5;
    localparam logic [7:0] OFF_INT_STATUS = 8'hD0;
    localparam logic [7:0] OFF_INT_MASK = 8'hD1;
    localparam logic [7:0] OFF_TEMP_CYCLE_TARGET = 8'hD2;
    // field limits
    localparam logic [14:0] INT_MAX = 15'h7FFF;
    localparam logic [15:0] FRAC_MAX = 16'hFFFF;
    localparam int COUNT_W = 8;
    // status bit positions
    localparam int ST_TEMP_DONE = 0;
    localparam int ST_TEMP_SAMPLE = 1;
    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_TARGET = 8'h01;
    localparam logic [1:0] RESET_MASK = 2'h0;
    // accumulator width, averages of up to 255 samples
    localparam int ACC_W = 39;
endpackage

// File: logic/temp_result_ram.sv
// small result store: one 16-bit word per result register slot
// single clock, written by the engine, read data registered
`timescale 1ns/100ps
module temp_result_ram #(
    parameter int ADDR_W = 3
) (
    input  wire logic              sys_clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [15:0]       wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [15:0]       rd_data
);
    logic [15:0] mem [0:(1<<ADDR_W)-1];

    // write port, no reset: contents are valid once written
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // temp_result_ram

// File: logic/temperature_result_registers.sv
// temperature result register bank: per-port discharge times, cycle count,
// and running averages; the times and averages in 4 MHz reference periods, the count in results
// assumes the measurement engine hands over one result per sequence as a
// same-clock pulse, and software reads over a plain strobe port
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module temperature_result_registers #(
    parameter int COUNT_W = temp_results_pkg::COUNT_W
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // measurement engine side, same clock
    input  wire logic        result_valid,
    input  wire logic        result_error,
    input  wire logic        result_from_seq_a,
    input  wire logic        result_from_seq_c,
    input  wire logic [14:0] port1_int_in,
    input  wire logic [15:0] port1_frac_in,
    input  wire logic [14:0] port2_int_in,
    input  wire logic [15:0] port2_frac_in,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             temp_event_done_flag,
    output logic             irq
);
    localparam int AW = temp_results_pkg::ACC_W;

    // all state in one word; the average words sit in the small stores
    typedef struct packed {
        logic [14:0]        p1_int;
        logic [15:0]        p1_frac;
        logic [14:0]        p2_int;
        logic [15:0]        p2_frac;
        logic [COUNT_W-1:0] cycles;
        logic [AW-1:0]      acc1;
        logic [AW-1:0]      acc2;
        logic [COUNT_W-1:0] target;
        logic [1:0]         status;
        logic [1:0]         mask;
        logic               done;
        logic               irq;
        logic               avg_ok;   // store slots hold a written average
        logic               bank;     // store slot with the newest average
        logic               rd_store; // read data come from the store
        logic [1:0]         rd_word;  // which average word is read
        logic [15:0]        rdata;
    } state_t;

    state_t st;
    state_t next_st;

    logic            accept;
    logic [AW-1:0]   sum1;
    logic [AW-1:0]   sum2;
    logic [AW-1:0]   q1;
    logic [AW-1:0]   q2;
    logic [COUNT_W-1:0] next_cycles;
    logic [COUNT_W-1:0] base_cycles;
    logic            group_full;
    logic [1:0]      ev;
    logic [15:0]     direct;
    logic            store_hit;
    logic [1:0]      store_word;
    logic            ram_waddr;
    logic            ram_we;
    logic            ram_raddr;
    logic [15:0]     avg_word [4];
    logic [15:0]     ram_rdata [4];

    // divide by the sample count; one combinational divide per port is the
    // price of returning the average at once instead of a multi-cycle engine
    function automatic logic [AW-1:0] avg_of(input logic [AW-1:0] sum,
                                           input logic [COUNT_W-1:0] n);
        logic [AW-1:0] q;
        q = '0;
        if (n != '0)
        begin
            q = sum / AW'(n);
        end
        return q;
    endfunction

    // quotient bits 30:16 are the integer, 15:0 the fraction
    function automatic logic [15:0] sat_int(input logic [AW-1:0] q);
        logic [15:0] r;
        r = {1'b0, q[30:16]};
        if (q[AW-1:31] != '0)
        begin
            r = {1'b0, temp_results_pkg::INT_MAX};
        end
        return r;
    endfunction

    function automatic logic [15:0] sat_frac(input logic [AW-1:0] q);
        logic [15:0] r;
        r = q[15:0];
        if (q[AW-1:31] != '0)
        begin
            r = temp_results_pkg::FRAC_MAX;
        end
        return r;
    endfunction

    // clean sequence from either event-timing command
    assign accept = result_valid && !result_error
                    && (result_from_seq_a || result_from_seq_c);
    // a finished group counts from one again even when the next result
    // follows at once, before the idle cycle that clears the count
    assign group_full  = st.done && (st.cycles >= st.target);
    assign base_cycles = group_full ? '0 : st.cycles;
    assign next_cycles = base_cycles + COUNT_W'(1);
    assign sum1 = (group_full ? '0 : st.acc1)
                  + AW'({port1_int_in, port1_frac_in});
    assign sum2 = (group_full ? '0 : st.acc2)
                  + AW'({port2_int_in, port2_frac_in});
    assign q1 = avg_of(sum1, next_cycles);
    assign q2 = avg_of(sum2, next_cycles);

    // averages live in small stores, one per word; each accept writes the
    // spare slot and flips the bank, so a read meeting an accept returns
    // the previous average and never races the write
    assign ram_we    = accept;
    assign ram_waddr = ~st.bank;
    assign ram_raddr = st.bank;
    assign avg_word[0] = sat_int(q1);
    assign avg_word[1] = sat_frac(q1);
    assign avg_word[2] = sat_int(q2);
    assign avg_word[3] = sat_frac(q2);

    // direct read mux, address decode as an if chain
    always_comb
    begin
        store_hit  = 1'b0;
        store_word = 2'h0;
        direct = temp_results_pkg::RESET_WORD;             // unmapped reads 0
        if (reg_addr == temp_results_pkg::OFF_PORT1_TEMP_INTEGER)
        begin
            direct = {1'b0, st.p1_int};
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT1_TEMP_FRACTION)
        begin
            direct = st.p1_frac;
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT2_TEMP_INTEGER)
        begin
            direct = {1'b0, st.p2_int};
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT2_TEMP_FRACTION)
        begin
            direct = st.p2_frac;
        end
        else if (reg_addr == temp_results_pkg::OFF_TEMP_CYCLES_AVERAGED)
        begin
            direct = 16'(st.cycles);
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT1_AVG_INTEGER)
        begin
            store_hit  = st.avg_ok;
            store_word = 2'h0;
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT1_AVG_FRACTION)
        begin
            store_hit  = st.avg_ok;
            store_word = 2'h1;
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT2_AVG_INTEGER)
        begin
            store_hit  = st.avg_ok;
            store_word = 2'h2;
        end
        else if (reg_addr == temp_results_pkg::OFF_PORT2_AVG_FRACTION)
        begin
            store_hit  = st.avg_ok;
            store_word = 2'h3;
        end
        else if (reg_addr == temp_results_pkg::OFF_INT_STATUS)
        begin
            direct = {14'h0000, st.status};
        end
        else if (reg_addr == temp_results_pkg::OFF_INT_MASK)
        begin
            direct = {14'h0000, st.mask};
        end
        else if (reg_addr == temp_results_pkg::OFF_TEMP_CYCLE_TARGET)
        begin
            direct = 16'(st.target);
        end
    end

    // next state
    always_comb
    begin
        next_st = st;
        ev = 2'h0;
        if (accept)
        begin
            next_st.p1_int  = port1_int_in;
            next_st.p1_frac = port1_frac_in;
            next_st.p2_int  = port2_int_in;
            next_st.p2_frac = port2_frac_in;
            next_st.acc1    = sum1;
            next_st.acc2    = sum2;
            next_st.avg_ok  = 1'b1;
            next_st.bank    = ~st.bank;
            ev[temp_results_pkg::ST_TEMP_SAMPLE] = 1'b1;
            if (next_cycles >= st.target)
            begin
                // target reached: flag, then start a fresh average
                ev[temp_results_pkg::ST_TEMP_DONE] = 1'b1;
                next_st.done   = 1'b1;
                next_st.cycles = next_cycles;
                next_st.acc1   = '0;
                next_st.acc2   = '0;
            end
            else
            begin
                next_st.cycles = next_cycles;
            end
        end
        else if (group_full)
        begin
            // restart counting after the completed group
            next_st.cycles = '0;
            next_st.acc1   = '0;
            next_st.acc2   = '0;
        end
        // software writes: only mask and target are writable
        if (reg_wr)
        begin
            if (reg_addr == temp_results_pkg::OFF_INT_MASK)
            begin
                next_st.mask = reg_wdata[1:0];
            end
            else if (reg_addr == temp_results_pkg::OFF_TEMP_CYCLE_TARGET)
            begin
                next_st.target = reg_wdata[COUNT_W-1:0];
            end
        end
        // status read clears; a new event in the same cycle wins
        if (reg_rd && reg_addr == temp_results_pkg::OFF_INT_STATUS)
        begin
            next_st.status = ev;
            next_st.done   = ev[temp_results_pkg::ST_TEMP_DONE];
        end
        else
        begin
            next_st.status = st.status | ev;
        end
        next_st.irq   = |(next_st.status & next_st.mask);
        next_st.rdata    = reg_rd ? direct : 16'h0000;
        next_st.rd_store = reg_rd && store_hit;
        next_st.rd_word  = store_word;
    end

    // one little store per average word
    genvar w;
    generate
        for (w = 0; w < 4; w++)
        begin : g_avg_store
            temp_result_ram #(
                .ADDR_W (1)
            ) u_store (
                .sys_clk (sys_clk),
                .wr_en   (ram_we),
                .wr_addr (ram_waddr),
                .wr_data (avg_word[w]),
                .rd_addr (ram_raddr),
                .rd_data (ram_rdata[w])
            );
        end
    endgenerate

    // state register, synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st        <= '0;
            st.target <= COUNT_W'(temp_results_pkg::RESET_TARGET);
            st.mask   <= temp_results_pkg::RESET_MASK;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs come straight from flops; average words come from the store's
    // own read flop, so the word pick is the one gate past a flop
    assign reg_rdata            = st.rd_store ? ram_rdata[st.rd_word]
                                              : st.rdata;
    assign temp_event_done_flag = st.done;
    assign irq                  = st.irq;
endmodule // temperature_result_registers

// File: verif/temp_results_props.sv
// checker for the temperature result register bank
// sees only the bank's top ports; bound in at the foot of this file
`timescale 1ns/100ps
module temp_results_props #(
    parameter int COUNT_W = 8
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        result_valid,
    input wire logic        result_error,
    input wire logic        result_from_seq_a,
    input wire logic        result_from_seq_c,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        temp_event_done_flag,
    input wire logic        irq
);
    // a result the bank must take, a mask write, a status read
    wire acc = result_valid && !result_error &&
        (result_from_seq_a || result_from_seq_c);
    wire wm = reg_wr && reg_addr == 8'hD1;
    wire sr = reg_rd && reg_addr == 8'hD0;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // read data only in the cycle after a strobe
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    AST_AVG_INT: assert property (
        reg_rd && reg_addr == 8'hF0 |=> !reg_rdata[15])
        else $error("average integer above 15 bits");
    AST_PORT_INT: assert property (
        reg_rd && (reg_addr == 8'hE7 || reg_addr == 8'hEB)
        |=> !reg_rdata[15]) else $error("port integer above 15 bits");
    AST_FLAG_CAUSE: assert property (
        $rose(temp_event_done_flag) |-> $past(acc))
        else $error("flag rose without a result");
    AST_FLAG_HOLD: assert property (
        temp_event_done_flag && !sr |=> temp_event_done_flag)
        else $error("flag dropped without status read");
    AST_FLAG_CLR: assert property (
        sr && !acc |=> !temp_event_done_flag)
        else $error("flag survived status read");
    // irq follows its cause at the next edge; the checks allow one or two edges
    AST_IRQ_CAUSE: assert property (
        $rose(irq) |-> $past(acc) || $past(acc, 2) || $past(wm)
        || $past(wm, 2)) else $error("irq rose without cause");
    AST_IRQ_CLR: assert property (
        sr && !acc ##1 !acc |-> ##[0:1] !irq)
        else $error("irq survived status read");
    COV_SEQ_C: cover property (acc && result_from_seq_c);
    COV_IRQ: cover property ($rose(irq));
    COV_CLR: cover property (sr && temp_event_done_flag);
endmodule // temp_results_props

bind temperature_result_registers temp_results_props #(
    .COUNT_W(COUNT_W)) u_props (.sys_clk(sys_clk), .rst(rst),
    .result_valid(result_valid), .result_error(result_error),
    .result_from_seq_a(result_from_seq_a),
    .result_from_seq_c(result_from_seq_c), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .temp_event_done_flag(temp_event_done_flag), .irq(irq));

// File: verif/host_model.sv
// host model: plain strobe master on the register port
// assumes the bank answers a read in the next cycle, never waits
`timescale 1ns/100ps
module host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    // idle bus from time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // data taken just after the strobe edge, while they stand
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule // host_model

// File: verif/temperature_result_registers_tb.sv
// testbench for the temperature result register bank
// host model on the register port; engine results driven here
`timescale 1ns/100ps
module temperature_result_registers_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        rv = 1'b0;
    logic        re = 1'b0;
    logic        sa = 1'b0;
    logic        sc = 1'b0;
    logic [14:0] i1 = 15'h0000;
    logic [15:0] f1 = 16'h0000;
    logic [14:0] i2 = 15'h0000;
    logic [15:0] f2 = 16'h0000;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic        reg_wr, reg_rd, flag, irq;
    int          err_total = 0;
    int          samples_checked = 0;
    always #50 sys_clk = ~sys_clk;
    temperature_result_registers DUT (.sys_clk(sys_clk), .rst(rst),
        .result_valid(rv), .result_error(re), .result_from_seq_a(sa),
        .result_from_seq_c(sc), .port1_int_in(i1), .port1_frac_in(f1),
        .port2_int_in(i2), .port2_frac_in(f2), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .temp_event_done_flag(flag), .irq(irq));
    host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask
    // one engine pulse; port two gets the inverse so the ports differ
    task automatic send(input logic e, a, c, input logic [14:0] i,
                        input logic [15:0] f);
        @(posedge sys_clk);
        rv <= 1'b1;
        re <= e;
        sa <= a;
        sc <= c;
        i1 <= i;
        f1 <= f;
        i2 <= ~i;
        f2 <= ~f;
        @(posedge sys_clk);
        rv <= 1'b0;
    endtask
    task automatic test_reset();
        logic [7:0] offs [8] = '{8'hE7, 8'hE8, 8'hEB, 8'hEC, 8'hEF,
                                 8'hF0, 8'hF1, 8'hFA};
        foreach (offs[k])
            rchk(offs[k], 16'h0000);
        chk({14'h0000, flag, irq}, 16'h0000);
        $display("test_reset done");
    endtask
    // largest times on port one, zero on port two; target 1 so the average is the sample
    task automatic test_max();
        send(1'b0, 1'b1, 1'b0, 15'h7FFF, 16'hFFFF);
        repeat (2) @(posedge sys_clk);
        rchk(8'hE7, 16'h7FFF);
        rchk(8'hE8, 16'hFFFF);
        rchk(8'hEB, 16'h0000);
        rchk(8'hEC, 16'h0000);
        rchk(8'hF0, 16'h7FFF);
        rchk(8'hF1, 16'hFFFF);
        chk({15'h0000, flag}, 16'h0001);
        host.rd(8'hD0, d);
        chk(d, 16'h0003);
        chk({15'h0000, flag}, 16'h0000);
        $display("test_max done");
    endtask
    // dropped results, both commands, masked sample bit, average of 3
    task automatic test_count();
        host.wr(8'hD2, 16'h0003);
        host.wr(8'hD1, 16'h0001);
        host.wr(8'hE7, 16'h1234);
        rchk(8'hD2, 16'h0003);
        rchk(8'hD1, 16'h0001);
        send(1'b1, 1'b1, 1'b0, 15'h0009, 16'h0000);
        send(1'b0, 1'b0, 1'b0, 15'h0009, 16'h0000);
        send(1'b0, 1'b1, 1'b0, 15'h0001, 16'h0000);
        send(1'b0, 1'b0, 1'b1, 15'h0002, 16'h0000);
        repeat (2) @(posedge sys_clk);
        rchk(8'hEF, 16'h0002);
        rchk(8'hE7, 16'h0002);
        chk({14'h0000, flag, irq}, 16'h0000);
        send(1'b0, 1'b1, 1'b0, 15'h0003, 16'h0000);
        repeat (2) @(posedge sys_clk);
        chk({14'h0000, flag, irq}, 16'h0003);
        rchk(8'hF0, 16'h0002);
        rchk(8'hF1, 16'h0000);
        rchk(8'hF4, 16'h7FFD);
        rchk(8'hF5, 16'hFFFF);
        rchk(8'hEF, 16'h0000);
        host.rd(8'hD0, d);
        chk(d, 16'h0003);
        repeat (2) @(posedge sys_clk);
        chk({14'h0000, flag, irq}, 16'h0000);
        $display("test_count done");
    endtask
    // two results on consecutive edges, the second right after the first finishes a group
    task automatic test_b2b();
        host.wr(8'hD2, 16'h0001);
        @(posedge sys_clk);
        rv <= 1'b1;
        re <= 1'b0;
        sa <= 1'b1;
        sc <= 1'b0;
        i1 <= 15'h0004;
        f1 <= 16'h0000;
        @(posedge sys_clk);
        i1 <= 15'h0006;
        @(posedge sys_clk);
        rv <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rchk(8'hF0, 16'h0006);
        rchk(8'hE7, 16'h0006);
        rchk(8'hEF, 16'h0000);
        host.rd(8'hD0, d);
        chk(d, 16'h0003);
        $display("test_b2b done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_max();
        test_count();
        test_b2b();
        test_done();
    end
    // watchdog: the tests need well under 3000 cycles
    initial
    begin
        #(3000 * 100);
        err_total++;
        test_done();
    end
endmodule // temperature_result_registers_tb
